// ---- hdl/svm_pkg.sv ----
// package: constants, register map and types of the supply voltage monitor control
package svm_pkg;
  // wishbone word offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h04;
  localparam logic [7:0] ADDR_PRIO_TWO = 8'h08;
  localparam logic [7:0] ADDR_EN_TWO = 8'h0C;
  localparam logic [7:0] ADDR_REQ_TWO = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  // control register fields
  localparam int CTRL_DIR_BIT = 7;
  localparam int CTRL_BGAP_BIT = 6;
  localparam int CTRL_RSTABLE_BIT = 5;
  localparam int CTRL_EN_BIT = 4;
  localparam int LEVEL_MSB = 3;
  localparam logic [3:0] LEVEL_EXTERNAL = 4'hF;
  localparam int EVENT_BIT = 2;
  localparam int GIE_BIT = 7;
  // status/mask bits of the wrapper interrupt block
  localparam int ST_EVENT = 0;
  localparam int ST_STABLE = 1;
  localparam int ST_WAKE = 2;
  localparam int ST_W = 3;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  // settle interval, counted in cycles of the 50 MHz core clock
  localparam int CLK_MHZ = 50;
  localparam int SETTLE_US = 20;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  localparam int SETTLE_W = 16;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } svm_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } svm_wb_rsp_t;

  typedef enum logic [1:0] {
    SVM_OFF,
    SVM_SETTLE,
    SVM_ARMED
  } svm_state_t;
endpackage : svm_pkg

// ---- hdl/svm_settle.sv ----
// settle timer: holds the reference-stable flag clear for a fixed interval after enable
`timescale 1ns/1ps
module svm_settle (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic [svm_pkg::SETTLE_W-1:0] cycles_i,
  output logic stable_o
);
  import svm_pkg::*;

  svm_state_t state_q, state_d;
  logic [SETTLE_W-1:0] cnt_q, cnt_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      SVM_OFF: begin
        cnt_d = '0;
        if (enable_i) begin
          state_d = SVM_SETTLE;
        end
      end
      SVM_SETTLE: begin
        // each enabling restarts the full interval
        if (!enable_i) begin
          state_d = SVM_OFF;
        end else if (cnt_q >= cycles_i - SETTLE_W'(1)) begin
          state_d = SVM_ARMED;
        end else begin
          cnt_d = cnt_q + SETTLE_W'(1);
        end
      end
      SVM_ARMED: begin
        if (!enable_i) begin
          state_d = SVM_OFF;
        end
      end
      default: state_d = SVM_OFF;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SVM_OFF;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign stable_o = (state_q == SVM_ARMED);
endmodule : svm_settle

// ---- hdl/svm_ctrl.sv ----
// supply voltage monitor control: registers, event flag, interrupt and wake logic
//
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps

// Summary of operation
// - The analog monitor is powered only while the enable bit 4 of the control register is set.
// - After every enabling the reference-stable flag at bit 5 stays clear until settling ends.
// - No event flag is set while the reference-stable flag is clear.
// - Direction bit 7 clear detects falling below the trip point, set detects rising above.
// - A comparator crossing in the chosen direction sets the voltage event flag.
// - Control bits 3:0 choose one of 16 trip levels for the comparator.
// - Level code 1111 routes the comparator input from the external trip input pin.
// - Event flag is request-two bit 2, its enable is enable-two bit 2, global enable bit 7.
// - Settling is timed by counting core clock cycles; excursions meanwhile may be missed.
// - While enabled the monitor runs in sleep and a crossing sets the flag and wakes the device.
// - On such a wake the core vectors only if interrupts are globally enabled.
// - Any reset returns all monitor registers to reset, leaving the monitor disabled.
// - Bandgap-stable bit 6 reads one when the bandgap references are stable.
module svm_ctrl #(
  parameter int SETTLE_CYCLES_P = svm_pkg::SETTLE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire svm_pkg::svm_wb_req_t wb_req_i,
  output svm_pkg::svm_wb_rsp_t wb_rsp_o,
  input wire logic cmp_above_i,
  input wire logic bandgap_stable_i,
  input wire logic sleep_i,
  output logic monitor_power_o,
  output logic [3:0] trip_level_select_o,
  output logic external_trip_input_sel_o,
  output logic voltage_event_irq_o,
  output logic voltage_event_priority_o,
  output logic wake_o,
  output logic vector_o,
  output logic irq_o
);
  import svm_pkg::*;

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] gctl_q, gctl_d;
  logic [7:0] prio2_q, prio2_d;
  logic [7:0] pen2_q, pen2_d;
  logic [7:0] preq2_q, preq2_d;
  logic [ST_W-1:0] ist_q, ist_d;
  logic [ST_W-1:0] imask_q, imask_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic cmp_prev_q, cmp_prev_d;
  logic stable_prev_q, stable_prev_d;
  logic wake_q, wake_d;
  logic vector_q, vector_d;

  logic stable;
  logic monitor_enable;
  logic direction_select;
  logic crossing;
  logic event_set;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] wbyte;
  logic [7:0] ctrl_view;

  // byte lane 0 only carries data; other lanes ignored
  function automatic logic [7:0] lane0(input svm_wb_req_t r, input logic [7:0] old);
    lane0 = r.sel[0] ? r.dat[7:0] : old;
  endfunction : lane0

  function automatic logic [31:0] zext8(input logic [7:0] v);
    zext8 = {24'h000000, v};
  endfunction : zext8

  // -----------------------------------------------------------------
  // settle timer
  // -----------------------------------------------------------------
  svm_settle u_settle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(monitor_enable),
    .cycles_i(SETTLE_W'(SETTLE_CYCLES_P)),
    .stable_o(stable)
  );

  assign monitor_enable = ctrl_q[CTRL_EN_BIT];
  assign direction_select = ctrl_q[CTRL_DIR_BIT];
  assign monitor_power_o = monitor_enable;
  assign trip_level_select_o = ctrl_q[LEVEL_MSB:0];
  assign external_trip_input_sel_o = (ctrl_q[LEVEL_MSB:0] == LEVEL_EXTERNAL);

  // status bits live on the read path, not in the stored byte
  always_comb begin
    ctrl_view = ctrl_q;
    ctrl_view[CTRL_RSTABLE_BIT] = stable;
    ctrl_view[CTRL_BGAP_BIT] = bandgap_stable_i;
  end

  // -----------------------------------------------------------------
  // crossing detect
  // -----------------------------------------------------------------
  // edge of comparator in chosen sense; the clock keeps running in sleep
  assign crossing = direction_select ? (cmp_above_i & ~cmp_prev_q)
                                     : (~cmp_above_i & cmp_prev_q);
  // no events until stable
  assign event_set = monitor_enable & stable & stable_prev_q & crossing;

  assign wr_stb = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~ack_q;
  assign rd_stb = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & ~ack_q;

  always_comb begin
    ctrl_d = ctrl_q;
    gctl_d = gctl_q;
    prio2_d = prio2_q;
    pen2_d = pen2_q;
    preq2_d = preq2_q;
    ist_d = ist_q;
    imask_d = imask_q;
    ack_d = 1'b0;
    rdat_d = rdat_q;
    wake_d = 1'b0;
    vector_d = 1'b0;
    cmp_prev_d = cmp_above_i;
    stable_prev_d = stable;
    wbyte = 8'h00;

    // -----------------------------------------------------------------
    // register writes
    // -----------------------------------------------------------------
    if (wr_stb) begin
      ack_d = 1'b1;
      case (wb_req_i.adr)
        ADDR_CTRL: begin
          wbyte = lane0(wb_req_i, ctrl_q);
          // bits 6 and 5 read-only
          ctrl_d = {wbyte[CTRL_DIR_BIT], 2'b00, wbyte[CTRL_EN_BIT:0]};
        end
        ADDR_IRQ_CTRL: gctl_d = lane0(wb_req_i, gctl_q);
        ADDR_PRIO_TWO: prio2_d = lane0(wb_req_i, prio2_q);
        ADDR_EN_TWO: pen2_d = lane0(wb_req_i, pen2_q);
        ADDR_REQ_TWO: preq2_d = lane0(wb_req_i, preq2_q);
        ADDR_IRQ_STATUS: begin
          if (wb_req_i.sel[0]) begin
            ist_d = ist_q & ~wb_req_i.dat[ST_W-1:0];
          end
        end
        ADDR_IRQ_MASK: begin
          if (wb_req_i.sel[0]) begin
            imask_d = wb_req_i.dat[ST_W-1:0];
          end
        end
        default: ack_d = 1'b1;
      endcase
    end

    // -----------------------------------------------------------------
    // reads
    // -----------------------------------------------------------------
    if (rd_stb) begin
      ack_d = 1'b1;
      case (wb_req_i.adr)
        ADDR_CTRL: rdat_d = zext8(ctrl_view);
        ADDR_IRQ_CTRL: rdat_d = zext8(gctl_q);
        ADDR_PRIO_TWO: rdat_d = zext8(prio2_q);
        ADDR_EN_TWO: rdat_d = zext8(pen2_q);
        ADDR_REQ_TWO: rdat_d = zext8(preq2_q);
        ADDR_IRQ_STATUS: rdat_d = {29'h00000000, ist_q};
        ADDR_IRQ_MASK: rdat_d = {29'h00000000, imask_q};
        default: rdat_d = 32'h00000000;
      endcase
    end

    // -----------------------------------------------------------------
    // events: set wins over a same-cycle clear
    // -----------------------------------------------------------------
    if (event_set) begin
      preq2_d[EVENT_BIT] = 1'b1;
      ist_d[ST_EVENT] = 1'b1;
      if (sleep_i) begin
        wake_d = 1'b1;
        vector_d = gctl_q[GIE_BIT] & pen2_q[EVENT_BIT];
        ist_d[ST_WAKE] = 1'b1;
      end
    end
    if (stable & ~stable_prev_q) begin
      ist_d[ST_STABLE] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
      gctl_q <= REG_RESET;
      prio2_q <= REG_RESET;
      pen2_q <= REG_RESET;
      preq2_q <= REG_RESET;
      ist_q <= '0;
      imask_q <= '0;
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
      cmp_prev_q <= 1'b0;
      stable_prev_q <= 1'b0;
      wake_q <= 1'b0;
      vector_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      gctl_q <= gctl_d;
      prio2_q <= prio2_d;
      pen2_q <= pen2_d;
      preq2_q <= preq2_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      cmp_prev_q <= cmp_prev_d;
      stable_prev_q <= stable_prev_d;
      wake_q <= wake_d;
      vector_q <= vector_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  always_comb begin
    wb_rsp_o.ack = ack_q;
    wb_rsp_o.dat = rdat_q;
  end

  // core interrupt request: flag, its enable and global enable
  assign voltage_event_irq_o = preq2_q[EVENT_BIT] & pen2_q[EVENT_BIT] & gctl_q[GIE_BIT];
  assign voltage_event_priority_o = prio2_q[EVENT_BIT];
  assign wake_o = wake_q;
  assign vector_o = vector_q;
  assign irq_o = |(ist_q & imask_q);
endmodule : svm_ctrl

// ---- tb/svm_ctrl_assertions.sv ----
// checker: port-level assertions of the voltage monitor control
`timescale 1ns/1ps
module svm_ctrl_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire svm_pkg::svm_wb_req_t wb_req_i,
  input wire svm_pkg::svm_wb_rsp_t wb_rsp_o,
  input wire logic cmp_above_i,
  input wire logic bandgap_stable_i,
  input wire logic sleep_i,
  input wire logic monitor_power_o,
  input wire logic [3:0] trip_level_select_o,
  input wire logic external_trip_input_sel_o,
  input wire logic voltage_event_irq_o,
  input wire logic voltage_event_priority_o,
  input wire logic wake_o,
  input wire logic vector_o,
  input wire logic irq_o
);
  import svm_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_once_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  ack_latency_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack
    |=> wb_rsp_o.ack) else $error("ack not one cycle after request");
  ext_select_a: assert property (
    external_trip_input_sel_o == (trip_level_select_o == LEVEL_EXTERNAL))
    else $error("external input select wrong");
  ctrl_hold_a: assert property (!(wb_req_i.cyc && wb_req_i.we)
    |=> $stable({monitor_power_o, trip_level_select_o})) else $error("ctrl moved");
  wake_cause_a: assert property (wake_o |-> $past(sleep_i) &&
    ($past(cmp_above_i) != $past(cmp_above_i, 2))) else $error("wake without cause");
  wake_pulse_a: assert property (wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
  vector_gate_a: assert property (vector_o |-> wake_o && voltage_event_irq_o)
    else $error("vector without enabled wake");
  flag_sticky_a: assert property (voltage_event_irq_o && !wb_req_i.cyc
    |=> voltage_event_irq_o) else $error("event flag dropped alone");
  reset_off_a: assert property ($fell(rst_i)
    |-> !monitor_power_o && !voltage_event_irq_o && !irq_o) else $error("not off");
endmodule : svm_ctrl_chk

bind svm_ctrl svm_ctrl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o), .cmp_above_i(cmp_above_i), .bandgap_stable_i(bandgap_stable_i),
  .sleep_i(sleep_i), .monitor_power_o(monitor_power_o),
  .trip_level_select_o(trip_level_select_o),
  .external_trip_input_sel_o(external_trip_input_sel_o),
  .voltage_event_irq_o(voltage_event_irq_o),
  .voltage_event_priority_o(voltage_event_priority_o), .wake_o(wake_o),
  .vector_o(vector_o), .irq_o(irq_o));

// ---- tb/tb.sv ----
// testbench: registers, event flag, interrupt and wake of the monitor control
`timescale 1ns/1ps
module tb;
  import svm_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cmp_q = 1;
  logic bg_q = 1;
  logic slp_q = 0;
  svm_wb_req_t req = '0;
  svm_wb_rsp_t rsp;
  logic pwr, ext, evi, pri, wk, vec, irq;
  logic [3:0] lvl;
  int error_cnt = 0;
  int checked = 0;
  int cyc_n = 0;
  // short settle keeps the run brief
  svm_ctrl #(.SETTLE_CYCLES_P(8)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_rsp_o(rsp), .cmp_above_i(cmp_q), .bandgap_stable_i(bg_q), .sleep_i(slp_q),
    .monitor_power_o(pwr), .trip_level_select_o(lvl), .external_trip_input_sel_o(ext),
    .voltage_event_irq_o(evi), .voltage_event_priority_o(pri), .wake_o(wk),
    .vector_o(vec), .irq_o(irq));
  always #10 clk_i = ~clk_i;
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : cmp
  task automatic cb(input string s, input logic e, input logic g);
    cmp(s, {7'h0, e}, {7'h0, g});
  endtask : cb
  // no cycle count assumed: the global timeout ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, a, 4'hF, {24'h0, d}};
    do @(posedge clk_i); while (rsp.ack !== 1'b1);
    q = rsp.dat[7:0];
    req <= '0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string s, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    cmp(s, e, q);
  endtask : rd
  task automatic step(input logic v);
    @(posedge clk_i);
    cmp_q <= v;
    repeat (3) @(posedge clk_i);
  endtask : step
  task automatic catch(input logic v, output logic w, output logic x);
    w = 1'b0;
    x = 1'b0;
    @(posedge clk_i);
    cmp_q <= v;
    repeat (4) begin
      @(negedge clk_i);
      w = w | wk;
      x = x | vec;
    end
  endtask : catch
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic t_reset;
    cb("power", 1'b0, pwr);
    rd("ctrl", ADDR_CTRL, 8'h40);
    bg_q <= 1'b0;
    rd("ctrl bg", ADDR_CTRL, 8'h00);
    bg_q <= 1'b1;
    rd("req2", ADDR_REQ_TWO, 8'h00);
    rd("unmapped", 8'h1C, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_setup;
    wr(ADDR_CTRL, 8'h0F);
    cb("ext", 1'b1, ext);
    cmp("level", 8'h0F, {4'h0, lvl});
    wr(ADDR_CTRL, 8'h1F);
    cb("power", 1'b1, pwr);
    cmp_q <= 1'b0;
    @(posedge clk_i);
    cmp_q <= 1'b1;
    rd("settling", ADDR_CTRL, 8'h5F);
    repeat (12) @(posedge clk_i);
    rd("stable", ADDR_CTRL, 8'h7F);
    rd("quiet", ADDR_REQ_TWO, 8'h00);
    $display("t_setup done");
  endtask : t_setup
  task automatic t_fall;
    step(1'b0);
    rd("fall", ADDR_REQ_TWO, 8'h04);
    wr(ADDR_REQ_TWO, 8'h00);
    step(1'b1);
    rd("rise ignored", ADDR_REQ_TWO, 8'h00);
    step(1'b0);
    wr(ADDR_CTRL, 8'h0F);
    rd("sticky", ADDR_REQ_TWO, 8'h04);
    $display("t_fall done");
  endtask : t_fall
  task automatic t_irq;
    wr(ADDR_EN_TWO, 8'h04);
    cb("no gie", 1'b0, evi);
    wr(ADDR_IRQ_CTRL, 8'h80);
    cb("gie", 1'b1, evi);
    wr(ADDR_PRIO_TWO, 8'h04);
    cb("prio", 1'b1, pri);
    rd("status", ADDR_IRQ_STATUS, 8'h03);
    wr(ADDR_IRQ_MASK, 8'h01);
    cb("irq", 1'b1, irq);
    wr(ADDR_IRQ_STATUS, 8'h01);
    cb("irq clr", 1'b0, irq);
    rd("w1c", ADDR_IRQ_STATUS, 8'h02);
    wr(ADDR_REQ_TWO, 8'h00);
    cb("flag clr", 1'b0, evi);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_sleep;
    logic w, v;
    wr(ADDR_CTRL, 8'h83);
    cb("ext off", 1'b0, ext);
    wr(ADDR_CTRL, 8'h93);
    repeat (12) @(posedge clk_i);
    wr(ADDR_REQ_TWO, 8'h00);
    slp_q <= 1'b1;
    catch(1'b1, w, v);
    cb("wake", 1'b1, w);
    cb("vector", 1'b1, v);
    rd("sleep flag", ADDR_REQ_TWO, 8'h04);
    rd("wake status", ADDR_IRQ_STATUS, 8'h07);
    wr(ADDR_IRQ_CTRL, 8'h00);
    catch(1'b0, w, v);
    cb("no fall wake", 1'b0, w);
    catch(1'b1, w, v);
    cb("wake", 1'b1, w);
    cb("no vector", 1'b0, v);
    // drive on the rising edge, check once the reset edge has settled
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    slp_q <= 1'b0;
    @(negedge clk_i);
    cb("power rst", 1'b0, pwr);
    rd("ctrl rst", ADDR_CTRL, 8'h40);
    $display("t_sleep done");
  endtask : t_sleep
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_setup();
    t_fall();
    t_irq();
    t_sleep();
    end_of_test();
  end
endmodule : tb
